/* hdl/rsc_map.svh */
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// bank-0 register addresses
`define RSC_ADDR_CFG 5'h00
`define RSC_ADDR_AUTO_ACK 5'h01
`define RSC_ADDR_RX_PIPES 5'h02
`define RSC_ADDR_STATUS 5'h07

// reset values and writable masks
`define RSC_RST_CFG 8'h08
`define RSC_RST_AUTO_ACK 8'h3F
`define RSC_RST_RX_PIPES 8'h03
`define RSC_MASK_CFG 8'h7F
`define RSC_MASK_PIPES 8'h3F

// main configuration field positions
`define RSC_BIT_RX_MASK 6
`define RSC_BIT_TX_MASK 5
`define RSC_BIT_RT_MASK 4
`define RSC_BIT_CRC_EN 3
`define RSC_BIT_CRC_LEN 2
`define RSC_BIT_POWER_UP_CTRL 1
`define RSC_BIT_PRIMARY_ROLE_SELECT 0

// status field positions
`define RSC_BIT_BANK 7
`define RSC_BIT_RX_FLAG 6
`define RSC_BIT_RT_FLAG 4

// command encodings
`define RSC_OPC_READ 3'h0
`define RSC_OPC_WRITE 3'h1
`define RSC_CMD_ACTIVATE 8'h50
`define RSC_BANK_KEY 8'h53

// bank-1 byte order split and last implemented index
`define RSC_B1_MSB_FIRST_LAST 5'h08
`define RSC_B1_LAST 5'h0E

`endif

/* hdl/rsc_pkg.sv */
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_OP_NONE = 2'h0,
    RSC_OP_READ = 2'h1,
    RSC_OP_WRITE = 2'h3,
    RSC_OP_ACTIVATE = 2'h2
  } rsc_op_t;

  typedef enum logic {
    RSC_EV_WRITE = 1'h0,
    RSC_EV_BANK = 1'h1
  } rsc_ev_t;

endpackage

/* hdl/rsc_sync2.sv */
`timescale 1ns/1ps
module rsc_sync2 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* hdl/rsc_bank1_mem.sv */
`timescale 1ns/1ps
module rsc_bank1_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [1:0] wlane,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [31:0] rdata
);
  // no reset: contents are undefined until software writes them
  logic [31:0] mem [0:15];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr][{wlane, 3'h0} +: 8] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* hdl/rsc_radio_spi_regs.sv */
`timescale 1ns/1ps
`include "rsc_map.svh"

// Notes on behaviour
// - bank 0, bank-1 9..14: LSB byte first
// - bank-1 0..8: MSB byte first
// - activate plus 0x53 toggles register bank
// - bank number reads in status bit 7
// - config bit 6 masks rx-ready interrupt
// - config bit 5 masks tx-sent interrupt
// - config bit 4 masks retry-limit interrupt
// - crc enable forced by any auto-ack
// - config bit 2 selects crc length
// - config bit 1 powers up, resets down
// - config bit 0 selects receiver or transmitter
// - auto-ack enables at 01, reset 3F
// - rx pipe enables at 02, reset 03
// - config 00, auto-ack 01, pipes 02, writable
// - read 000aaaaa, write 001aaaaa command bytes
// - activate command 0x50 with one data byte
module rsc_radio_spi_regs
  import rsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sck,
  input wire logic csn,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  input wire logic rx_ready_evt,
  input wire logic tx_sent_evt,
  input wire logic retry_limit_evt,
  output logic irq_n,
  output logic rx_ready_irq_mask,
  output logic tx_sent_irq_mask,
  output logic retry_limit_irq_mask,
  output logic crc_enable,
  output logic crc_length_select,
  output logic power_up_ctrl,
  output logic primary_role_select,
  output logic [5:0] auto_ack_pipes,
  output logic [5:0] rx_pipe_enables,
  output logic bank_select
);

  function automatic rsc_op_t op_of(input logic [7:0] c);
    if (c[7:5] == `RSC_OPC_READ) begin
      return RSC_OP_READ;
    end else if (c[7:5] == `RSC_OPC_WRITE) begin
      return RSC_OP_WRITE;
    end else if (c == `RSC_CMD_ACTIVATE) begin
      return RSC_OP_ACTIVATE;
    end
    return RSC_OP_NONE;
  endfunction

  // byte lane of a bank-1 word for the n-th data byte
  function automatic logic [1:0] lane_of(input logic [4:0] a, input logic [2:0] idx);
    if (a <= `RSC_B1_MSB_FIRST_LAST) begin
      return 2'h3 - idx[1:0];
    end
    return idx[1:0];
  endfunction

  // ---------------- link side, clocked by sck ----------------
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [6:0] sh_reg;
  logic [7:0] cmd_reg;
  logic miso_reg;
  logic shifted_reg;
  logic ev_tog_reg;
  rsc_ev_t ev_kind_reg;
  logic [4:0] ev_addr_reg;
  logic [7:0] ev_data_reg;

  // clk-side snapshot, frozen while a frame is open
  logic [31:0] snap_reg;
  logic [31:0] mem_rdata;

  wire logic [7:0] in_byte = {sh_reg, mosi};
  wire logic byte_done = (bit_cnt_reg == 3'h7);
  wire rsc_op_t cmd_op = op_of(cmd_reg);
  wire logic [7:0] snap_cfg = snap_reg[7:0];
  wire logic [7:0] snap_aa = snap_reg[15:8];
  wire logic [7:0] snap_rxp = snap_reg[23:16];
  wire logic [7:0] snap_status = snap_reg[31:24];
  wire logic bank1 = snap_status[`RSC_BIT_BANK];
  wire logic [2:0] data_idx = byte_cnt_reg - 3'h1;
  wire logic in_word = (byte_cnt_reg != 3'h0) && (byte_cnt_reg <= 3'h4);
  wire logic b1_hit = bank1 && (cmd_reg[4:0] <= `RSC_B1_LAST);
  wire logic [1:0] mem_lane = lane_of(cmd_reg[4:0], data_idx);
  wire logic mem_we = byte_done && (cmd_op == RSC_OP_WRITE) && b1_hit && in_word;
  wire logic [3:0] mem_raddr = (byte_cnt_reg == 3'h0) ? in_byte[3:0] : cmd_reg[3:0];
  wire logic [7:0] mem_byte = mem_rdata[{mem_lane, 3'h0} +: 8];

  wire logic [7:0] b0_rd =
    (cmd_reg[4:0] == `RSC_ADDR_CFG) ? snap_cfg :
    (cmd_reg[4:0] == `RSC_ADDR_AUTO_ACK) ? snap_aa :
    (cmd_reg[4:0] == `RSC_ADDR_RX_PIPES) ? snap_rxp :
    (cmd_reg[4:0] == `RSC_ADDR_STATUS) ? snap_status : 8'h00;

  // byte on miso: status while the command comes in, then read data
  wire logic rd_b1 = (cmd_op == RSC_OP_READ) && b1_hit && in_word;
  wire logic rd_b0 = (cmd_op == RSC_OP_READ) && !bank1 && (byte_cnt_reg == 3'h1);
  wire logic [7:0] cur_tx =
    (byte_cnt_reg == 3'h0) ? snap_status :
    rd_b1 ? mem_byte :
    rd_b0 ? b0_rd : 8'h00;

  wire logic ev_b0_write = byte_done && (byte_cnt_reg == 3'h1) &&
    (cmd_op == RSC_OP_WRITE) && !bank1;
  wire logic ev_bank = byte_done && (byte_cnt_reg == 3'h1) &&
    (cmd_op == RSC_OP_ACTIVATE) && (in_byte == `RSC_BANK_KEY);
  wire logic ev_fire = ev_b0_write || ev_bank;

  // frame state is cleared by csn itself since sck stops between frames
  always_ff @(posedge sck or posedge csn) begin
    if (csn) begin
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      sh_reg <= 7'h00;
      cmd_reg <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      sh_reg <= in_byte[6:0];
      if (byte_done && byte_cnt_reg == 3'h0) begin
        cmd_reg <= in_byte;
      end
      if (byte_done && byte_cnt_reg != 3'h7) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // data changes on the falling edge, msb of each byte first
  always_ff @(negedge sck or posedge csn) begin
    if (csn) begin
      miso_reg <= 1'b0;
      shifted_reg <= 1'b0;
    end else begin
      miso_reg <= cur_tx[~bit_cnt_reg];
      shifted_reg <= 1'b1;
    end
  end

  // event word held stable for at least eight sck edges, toggle crosses
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      ev_tog_reg <= 1'b0;
      ev_kind_reg <= RSC_EV_WRITE;
      ev_addr_reg <= 5'h00;
      ev_data_reg <= 8'h00;
    end else if (ev_fire) begin
      ev_tog_reg <= ~ev_tog_reg;
      ev_kind_reg <= ev_bank ? RSC_EV_BANK : RSC_EV_WRITE;
      ev_addr_reg <= cmd_reg[4:0];
      ev_data_reg <= in_byte;
    end
  end

  rsc_bank1_mem u_bank1 (
    .clk(sck),
    .we(mem_we),
    .waddr(cmd_reg[3:0]),
    .wlane(mem_lane),
    .wdata(in_byte),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // the first bit is out before any sck edge, so it is picked from the snapshot
  assign miso_o = shifted_reg ? miso_reg : snap_status[`RSC_BIT_BANK];
  assign miso_oe = ~csn;

  // ---------------- register side, clocked by clk ----------------
  logic ev_tog_s;
  logic csn_s;
  logic ev_seen_reg;
  logic [7:0] cfg_reg;
  logic [7:0] aa_reg;
  logic [7:0] rxp_reg;
  logic bank_reg;
  logic [2:0] flags_reg;
  logic irq_n_reg;

  rsc_sync2 #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({ev_tog_reg, csn}),
    .q({ev_tog_s, csn_s})
  );

  wire logic ev_new = (ev_tog_s != ev_seen_reg);
  wire logic ev_wr = ev_new && (ev_kind_reg == RSC_EV_WRITE);
  wire logic wr_cfg = ev_wr && (ev_addr_reg == `RSC_ADDR_CFG);
  wire logic wr_aa = ev_wr && (ev_addr_reg == `RSC_ADDR_AUTO_ACK);
  wire logic wr_rxp = ev_wr && (ev_addr_reg == `RSC_ADDR_RX_PIPES);
  wire logic wr_status = ev_wr && (ev_addr_reg == `RSC_ADDR_STATUS);
  wire logic bank_flip = ev_new && (ev_kind_reg == RSC_EV_BANK);

  wire logic [7:0] aa_next = wr_aa ? (ev_data_reg & `RSC_MASK_PIPES) : aa_reg;
  wire logic [7:0] rxp_next = wr_rxp ? (ev_data_reg & `RSC_MASK_PIPES) : rxp_reg;
  wire logic [7:0] cfg_wr = wr_cfg ? (ev_data_reg & `RSC_MASK_CFG) : cfg_reg;
  wire logic [7:0] crc_force = (|aa_next) ? (8'h01 << `RSC_BIT_CRC_EN) : 8'h00;
  wire logic [7:0] cfg_next = cfg_wr | crc_force;

  // set beats a write-one clear in the same cycle
  wire logic [2:0] flag_set = {rx_ready_evt, tx_sent_evt, retry_limit_evt};
  wire logic [2:0] flag_clr =
    wr_status ? ev_data_reg[`RSC_BIT_RX_FLAG:`RSC_BIT_RT_FLAG] : 3'h0;
  wire logic [2:0] flags_next = (flags_reg & ~flag_clr) | flag_set;
  wire logic [2:0] irq_masks = cfg_next[`RSC_BIT_RX_MASK:`RSC_BIT_RT_MASK];
  wire logic irq_n_next = ~|(flags_next & ~irq_masks);
  wire logic bank_next = bank_reg ^ bank_flip;
  wire logic [7:0] status_val = {bank_reg, flags_reg, 4'h0};
  // snapshot only moves while csn is high so sck logic sees stable bits
  wire logic [31:0] snap_next =
    csn_s ? {status_val, rxp_reg, aa_reg, cfg_reg} : snap_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_seen_reg <= 1'b0;
      cfg_reg <= `RSC_RST_CFG;
      aa_reg <= `RSC_RST_AUTO_ACK;
      rxp_reg <= `RSC_RST_RX_PIPES;
      bank_reg <= 1'b0;
      flags_reg <= 3'h0;
      irq_n_reg <= 1'b1;
      snap_reg <= {8'h00, `RSC_RST_RX_PIPES, `RSC_RST_AUTO_ACK, `RSC_RST_CFG};
    end else if (ce) begin
      ev_seen_reg <= ev_tog_s;
      cfg_reg <= cfg_next;
      aa_reg <= aa_next;
      rxp_reg <= rxp_next;
      bank_reg <= bank_next;
      flags_reg <= flags_next;
      irq_n_reg <= irq_n_next;
      snap_reg <= snap_next;
    end
  end

  assign irq_n = irq_n_reg;
  assign rx_ready_irq_mask = cfg_reg[`RSC_BIT_RX_MASK];
  assign tx_sent_irq_mask = cfg_reg[`RSC_BIT_TX_MASK];
  assign retry_limit_irq_mask = cfg_reg[`RSC_BIT_RT_MASK];
  assign crc_enable = cfg_reg[`RSC_BIT_CRC_EN];
  assign crc_length_select = cfg_reg[`RSC_BIT_CRC_LEN];
  assign power_up_ctrl = cfg_reg[`RSC_BIT_POWER_UP_CTRL];
  assign primary_role_select = cfg_reg[`RSC_BIT_PRIMARY_ROLE_SELECT];
  assign auto_ack_pipes = aa_reg[5:0];
  assign rx_pipe_enables = rxp_reg[5:0];
  assign bank_select = bank_reg;

  // ---------------- checks ----------------
  crc_forced_a:
    assert property (@(posedge clk) disable iff (rst)
      (|aa_reg) |-> cfg_reg[`RSC_BIT_CRC_EN])
    else $error("crc enable low while an auto-ack bit is set");

  irq_rx_mask_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && rx_ready_evt && !cfg_reg[`RSC_BIT_RX_MASK] && !wr_cfg) |=> !irq_n_reg)
    else $error("unmasked rx-ready event did not pull irq low");

  irq_tx_mask_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && tx_sent_evt && !cfg_reg[`RSC_BIT_TX_MASK] && !wr_cfg) |=> !irq_n_reg)
    else $error("unmasked tx-sent event did not pull irq low");

  irq_retry_mask_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && retry_limit_evt && !cfg_reg[`RSC_BIT_RT_MASK] && !wr_cfg) |=> !irq_n_reg)
    else $error("unmasked retry-limit event did not pull irq low");

  irq_all_masked_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && cfg_reg[6:4] == 3'h7 && !wr_cfg) |=> irq_n_reg)
    else $error("irq asserted with every source masked");

  bank_toggle_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && bank_flip) |=> (bank_reg != $past(bank_reg)))
    else $error("bank did not toggle on key byte");

  bank_report_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && csn_s) |=> (snap_reg[31] == $past(bank_reg)))
    else $error("status bit 7 does not show the bank");

  cfg_reset_a:
    assert property (@(posedge clk) rst |=> (cfg_reg == `RSC_RST_CFG))
    else $error("configuration reset value wrong");

  aa_reset_a:
    assert property (@(posedge clk) rst |=> (aa_reg == `RSC_RST_AUTO_ACK))
    else $error("auto-ack reset value wrong");

  rxp_reset_a:
    assert property (@(posedge clk) rst |=> (rxp_reg == `RSC_RST_RX_PIPES))
    else $error("rx pipe enable reset value wrong");

  cfg_write_a:
    assert property (@(posedge clk) disable iff (rst)
      (ce && wr_cfg) |=> ((cfg_reg & 8'h07) == ($past(ev_data_reg) & 8'h07)))
    else $error("configuration low bits not written");

  status_shift_a:
    assert property (@(posedge sck) disable iff (csn)
      (byte_cnt_reg == 3'h0 && shifted_reg) |-> miso_reg == snap_reg[{2'b11, ~bit_cnt_reg}])
    else $error("status bit on miso wrong during command byte");

  lane_order_a:
    assert property (@(posedge sck) disable iff (csn)
      mem_we |-> (mem_lane == ((cmd_reg[4:0] <= 5'h08) ? (2'h3 - data_idx[1:0])
        : data_idx[1:0])))
    else $error("bank-1 byte lane order wrong");

endmodule

/* testbench/rsc_host_model.sv */
`timescale 1ns/1ps
module rsc_host_model (
  output logic sck,
  output logic csn,
  output logic mosi,
  input wire logic miso
);
  // sck parked low outside frames, mode 0
  initial begin
    sck = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end

  // command byte then n data bytes, wd byte 0 goes first
  // caller orders bank-1 lanes; this model just streams bytes
  task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                       output logic [7:0] st, output logic [31:0] rd);
    logic [7:0] b;
    logic [7:0] r;
    rd = 32'h0;
    st = 8'h00;
    csn = 1'b0;
    #130;
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? cmd : wd[8*(k-1) +: 8];
      for (int i = 7; i >= 0; i--) begin
        mosi = b[i];
        #32 sck = 1'b1;
        r[i] = miso;
        #32 sck = 1'b0;
      end
      if (k == 0) st = r;
      else rd[8*(k-1) +: 8] = r;
    end
    #40 csn = 1'b1;
    // released line must not keep the last bit
    mosi = ~mosi;
    // long gap so writes land and status refreshes
    #400;
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "rsc_map.svh"
module tb;
  import rsc_pkg::*;
  logic clk;
  logic rst;
  logic ce;
  logic [2:0] evt;
  logic sck, csn, mosi, miso_o, miso_oe, irq_n, bank_select;
  logic [6:0] cfg_pins;
  logic [5:0] auto_ack_pipes, rx_pipe_enables;
  logic [7:0] st, d;
  logic [31:0] rd;
  int bad_count = 0;
  int checked = 0;

  rsc_radio_spi_regs dut (.clk(clk), .rst(rst), .ce(ce), .sck(sck), .csn(csn), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .rx_ready_evt(evt[0]), .tx_sent_evt(evt[1]),
    .retry_limit_evt(evt[2]), .irq_n(irq_n), .rx_ready_irq_mask(cfg_pins[6]),
    .tx_sent_irq_mask(cfg_pins[5]), .retry_limit_irq_mask(cfg_pins[4]),
    .crc_enable(cfg_pins[3]), .crc_length_select(cfg_pins[2]), .power_up_ctrl(cfg_pins[1]),
    .primary_role_select(cfg_pins[0]), .auto_ack_pipes(auto_ack_pipes),
    .rx_pipe_enables(rx_pipe_enables), .bank_select(bank_select));

  rsc_host_model host (.sck(sck), .csn(csn), .mosi(mosi), .miso(miso_o));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // host keeps reserved bits zero and writes only while idle
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 host.frame({`RSC_OPC_WRITE, a}, 1, {24'h0, v}, st, rd);
  endtask

  task automatic rdr(input logic [4:0] a);
    @(posedge clk);
    #1 host.frame({`RSC_OPC_READ, a}, 1, 32'h0, st, rd);
    d = rd[7:0];
  endtask

  task automatic act(input logic [7:0] key);
    @(posedge clk);
    #1 host.frame(`RSC_CMD_ACTIVATE, 1, {24'h0, key}, st, rd);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    #1 evt[i] = 1'b1;
    @(posedge clk);
    #1 evt[i] = 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    evt = 3'h0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    rdr(`RSC_ADDR_CFG);
    chk("cfg", 8'h08, d);
    chk("status", 8'h00, st);
    chk("cfg_pins", 7'h08, cfg_pins);
    chk("miso_oe_idle", 1'b0, miso_oe);
    rdr(`RSC_ADDR_AUTO_ACK);
    chk("auto_ack", 8'h3F, d);
    rdr(`RSC_ADDR_RX_PIPES);
    chk("rx_pipes", 8'h03, d);
    chk("pipe_pins", 12'hFC3, {auto_ack_pipes, rx_pipe_enables});
    $display("test reset done");
    // each config bit alone; crc stays forced by auto-ack
    for (int b = 0; b < 7; b++) begin
      wr(`RSC_ADDR_CFG, 8'h01 << b);
      rdr(`RSC_ADDR_CFG);
      chk("cfg", (8'h01 << b) | 8'h08, d);
      chk("cfg_pins", (7'h01 << b) | 7'h08, cfg_pins);
    end
    wr(`RSC_ADDR_AUTO_ACK, 8'h00);
    wr(`RSC_ADDR_CFG, 8'h00);
    rdr(`RSC_ADDR_CFG);
    chk("cfg_free", 8'h00, d);
    wr(`RSC_ADDR_AUTO_ACK, 8'h20);
    rdr(`RSC_ADDR_CFG);
    chk("cfg_forced", 8'h08, d);
    rdr(`RSC_ADDR_AUTO_ACK);
    chk("auto_ack", 8'h20, d);
    wr(`RSC_ADDR_RX_PIPES, 8'h3C);
    rdr(`RSC_ADDR_RX_PIPES);
    chk("rx_pipes", 8'h3C, d);
    chk("pipe_pins", 12'h83C, {auto_ack_pipes, rx_pipe_enables});
    wr(5'h03, 8'hAA);
    rdr(5'h03);
    chk("unmapped", 8'h00, d);
    $display("test config done");
    // masked flag keeps the pin high, unmasking drops it
    for (int i = 0; i < 3; i++) begin
      wr(`RSC_ADDR_CFG, 8'h40 >> i);
      pulse(i);
      chk("irq_masked", 1'b1, irq_n);
      rdr(`RSC_ADDR_CFG);
      chk("status_flag", 8'h40 >> i, st);
      wr(`RSC_ADDR_CFG, 8'h00);
      chk("irq_live", 1'b0, irq_n);
      wr(`RSC_ADDR_STATUS, 8'h40 >> i);
      chk("irq_clear", 1'b1, irq_n);
    end
    // every source masked: flags set but the pin stays high
    wr(`RSC_ADDR_CFG, 8'h70);
    pulse(0);
    pulse(1);
    pulse(2);
    chk("irq_all_masked", 1'b1, irq_n);
    wr(`RSC_ADDR_STATUS, 8'h70);
    wr(`RSC_ADDR_CFG, 8'h00);
    chk("irq_none", 1'b1, irq_n);
    $display("test irq done");
    act(8'h73);
    chk("bank_wrong_key", 1'b0, bank_select);
    act(`RSC_BANK_KEY);
    chk("bank_select", 1'b1, bank_select);
    rdr(`RSC_ADDR_CFG);
    chk("status_bank", 8'h80, st);
    @(posedge clk);
    #1 host.frame({`RSC_OPC_WRITE, 5'h09}, 4, 32'h44332211, st, rd);
    @(posedge clk);
    #1 host.frame({`RSC_OPC_READ, 5'h09}, 4, 32'h0, st, rd);
    chk("bank1_r9", 32'h44332211, rd);
    @(posedge clk);
    #1 host.frame({`RSC_OPC_WRITE, 5'h02}, 4, 32'hA1B2C3D4, st, rd);
    @(posedge clk);
    #1 host.frame({`RSC_OPC_READ, 5'h02}, 4, 32'h0, st, rd);
    chk("bank1_r2", 32'hA1B2C3D4, rd);
    act(`RSC_BANK_KEY);
    chk("bank_back", 1'b0, bank_select);
    rdr(`RSC_ADDR_CFG);
    chk("cfg_kept", 8'h08, d);
    chk("status_bank0", 8'h00, st);
    $display("test bank done");
    give_verdict();
  end
endmodule
